// ---- common/asp_pkg.sv ----
// Purpose: shared constants and types for the asynchronous serial port
// Assumes: 32-bit APB, one aligned word per register
// Notes:   all offsets are byte addresses
package asp_pkg;

	// register byte offsets
	localparam logic [7:0] ASP_OFF_CTRL   = 8'h00;
	localparam logic [7:0] ASP_OFF_DATA   = 8'h04;
	localparam logic [7:0] ASP_OFF_RELOAD = 8'h08;
	localparam logic [7:0] ASP_OFF_TCFG   = 8'h0C;
	localparam logic [7:0] ASP_OFF_LOW    = 8'h10;

	// serial_control field positions
	localparam int ASP_CB_MODE = 7;
	localparam int ASP_CB_ONE  = 6;
	localparam int ASP_CB_MCE  = 5;
	localparam int ASP_CB_REN  = 4;
	localparam int ASP_CB_TB8  = 3;
	localparam int ASP_CB_RB8  = 2;
	localparam int ASP_CB_TI   = 1;
	localparam int ASP_CB_RI   = 0;
	localparam logic [7:0] ASP_CTRL_RESET = 8'h40;

	// timer config field positions
	localparam int ASP_TB_RUN = 0;
	localparam int ASP_TB_SRC = 1;
	localparam int ASP_TB_IEN = 4;
	localparam logic [7:0] ASP_TCFG_RESET   = 8'h00;
	localparam logic [7:0] ASP_RELOAD_RESET = 8'h00;
	localparam logic [7:0] ASP_LOW_RESET    = 8'h00;
	localparam logic [7:0] ASP_LOW_TOP      = 8'hFF;

	// timer clock sources
	localparam logic [2:0] ASP_SRC_SYS   = 3'h0;
	localparam logic [2:0] ASP_SRC_DIV4  = 3'h1;
	localparam logic [2:0] ASP_SRC_DIV12 = 3'h2;
	localparam logic [2:0] ASP_SRC_DIV48 = 3'h3;
	localparam logic [2:0] ASP_SRC_OSC8  = 3'h4;
	localparam logic [2:0] ASP_SRC_PIN   = 3'h5;

	// prescaler terminal counts
	localparam logic [1:0] ASP_DIV4_LAST  = 2'h3;
	localparam logic [3:0] ASP_DIV12_LAST = 4'hB;
	localparam logic [5:0] ASP_DIV48_LAST = 6'h2F;
	localparam logic [2:0] ASP_OSC8_LAST  = 3'h7;

	// frame bit indices
	localparam logic [3:0] ASP_LAST_BIT8 = 4'h9;
	localparam logic [3:0] ASP_LAST_BIT9 = 4'hA;
	localparam logic [2:0] ASP_DATA_LAST = 3'h7;

	typedef enum logic [2:0] {ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_NINTH,
		ASP_RX_STOP} asp_rx_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} asp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} asp_apb_rsp_t;

	typedef struct packed {
		logic [7:0]    ctrl;
		logic [7:0]    tcfg;
		logic [7:0]    reload;
		logic [7:0]    low;
		logic [7:0]    rx_cnt;
		logic [7:0]    rx_buf;
		logic [1:0]    p4;
		logic [3:0]    p12;
		logic [5:0]    p48;
		logic [2:0]    pext;
		logic [2:0]    rxd_s;
		logic [2:0]    osc_s;
		logic [2:0]    tin_s;
		logic          tx_half;
		logic          rx_half;
		logic          tx_busy;
		logic [3:0]    tx_idx;
		logic [10:0]   tx_frame;
		logic          txd;
		asp_rx_state_t rx_state;
		logic [2:0]    rx_idx;
		logic [7:0]    rx_shift;
		logic          rx_ninth;
		logic          irq;
		asp_apb_rsp_t  rsp;
	} asp_state_t;

endpackage

// ---- hdl/asp_serial_port.sv ----
// Purpose: asynchronous serial port with its own baud timer, APB slave
// Assumes: ext_osc well below clk/4, pins asynchronous to clk
// Notes:   every APB transfer takes one setup and one access cycle
// Notes on behaviour
// - full duplex, 8-bit or 9-bit frames picked by the frame mode bit
// - receive shifter separate from receive buffer, so a new byte may arrive
// - writing the data buffer loads the transmit frame and starts sending
// - reading the data buffer gives the received byte, never transmit data
// - interrupt when enabled and either done flag is set
// - done flags stay set until software clears them
// - transmit clock from low count byte, 8-bit auto-reload counter
// - hidden receive counter runs with timer enabled, same reload value
// - both counter overflows divided by two for the bit rates
// - start edge on the receive line forces the receive counter reload
// - timer clock from system clock, /4, /12, /48, oscillator /8, or pin
// - overflow rate is timer clock over 256 minus reload; bit rate half
// - system clock runs while the external oscillator feeds the timer
// - 8-bit frame: start, eight data LSB first, stop into received ninth
// - 9-bit frame sends ninth bit setting; receive stores ninth, waits for stop but ignores its level
// - transmit-done set at the start of the stop bit
// - load and flag only if flag clear and, with filter on, bit is one
`timescale 1ns/10ps
module asp_serial_port
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire asp_pkg::asp_apb_req_t apb_req,
	output      asp_pkg::asp_apb_rsp_t apb_rsp,
	input  wire logic                  rxd,
	output      logic                  txd,
	input  wire logic                  ext_osc,
	input  wire logic                  timer_ext_input,
	output      logic                  port_irq
);

	asp_pkg::asp_state_t r;
	asp_pkg::asp_state_t n;

	logic       setup;
	logic       wr;
	logic       wr_ctrl;
	logic       wr_low;
	logic       run;
	logic [2:0] src;
	logic       tick;
	logic       osc_rise;
	logic       tin_rise;
	logic       tx_ovf;
	logic       rx_ovf;
	logic       tx_bit;
	logic       rx_samp;
	logic       start_det;
	logic       mode9;
	logic [3:0] last;
	logic       rxb;
	logic       ti_set;
	logic       rx_load;
	logic       rx_bit;

	function automatic logic asp_sel(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic asp_mapped(input logic [7:0] a);
		return asp_sel(a, asp_pkg::ASP_OFF_CTRL) || asp_sel(a, asp_pkg::ASP_OFF_DATA)
			|| asp_sel(a, asp_pkg::ASP_OFF_RELOAD) || asp_sel(a, asp_pkg::ASP_OFF_TCFG)
			|| asp_sel(a, asp_pkg::ASP_OFF_LOW);
	endfunction

	always_comb
	begin
		n         = r;
		setup     = apb_req.psel && !apb_req.penable;
		wr        = apb_req.psel && apb_req.penable && r.rsp.pready && apb_req.pwrite;
		wr_ctrl   = wr && asp_sel(apb_req.paddr, asp_pkg::ASP_OFF_CTRL);
		wr_low    = wr && asp_sel(apb_req.paddr, asp_pkg::ASP_OFF_LOW);
		run       = r.tcfg[asp_pkg::ASP_TB_RUN];
		src       = r.tcfg[asp_pkg::ASP_TB_SRC +: 3];
		mode9     = r.ctrl[asp_pkg::ASP_CB_MODE];
		last      = mode9 ? asp_pkg::ASP_LAST_BIT9 : asp_pkg::ASP_LAST_BIT8;
		rxb       = r.rxd_s[1];
		tx_ovf    = 1'b0;
		rx_ovf    = 1'b0;
		ti_set    = 1'b0;
		rx_load   = 1'b0;
		rx_bit    = 1'b0;

		// pin synchronisers; stage 2 is a delayed copy for edge detection
		n.rxd_s = {r.rxd_s[1:0], rxd};
		n.osc_s = {r.osc_s[1:0], ext_osc};
		n.tin_s = {r.tin_s[1:0], timer_ext_input};
		osc_rise = r.osc_s[1] && !r.osc_s[2];
		tin_rise = r.tin_s[1] && !r.tin_s[2];

		// prescalers free-run so a source switch never waits for a restart
		n.p4  = r.p4 + 2'h1;
		n.p12 = (r.p12 == asp_pkg::ASP_DIV12_LAST) ? 4'h0 : r.p12 + 4'h1;
		n.p48 = (r.p48 == asp_pkg::ASP_DIV48_LAST) ? 6'h00 : r.p48 + 6'h01;
		n.pext = r.pext + {2'h0, osc_rise};

		unique case (src)
			asp_pkg::ASP_SRC_SYS:   tick = 1'b1;
			asp_pkg::ASP_SRC_DIV4:  tick = r.p4 == asp_pkg::ASP_DIV4_LAST;
			asp_pkg::ASP_SRC_DIV12: tick = r.p12 == asp_pkg::ASP_DIV12_LAST;
			asp_pkg::ASP_SRC_DIV48: tick = r.p48 == asp_pkg::ASP_DIV48_LAST;
			asp_pkg::ASP_SRC_OSC8:  tick = osc_rise && r.pext == asp_pkg::ASP_OSC8_LAST;
			asp_pkg::ASP_SRC_PIN:   tick = tin_rise;
			default:                tick = 1'b0;
		endcase

		// transmit timer: low count byte, auto-reload on overflow
		if (tick && run)
		begin
			if (r.low == asp_pkg::ASP_LOW_TOP)
			begin
				n.low  = r.reload;
				tx_ovf = 1'b1;
			end
			else
			begin
				n.low = r.low + 8'h01;
			end
		end

		start_det = r.rx_state == asp_pkg::ASP_RX_IDLE && r.ctrl[asp_pkg::ASP_CB_REN]
			&& run && !r.rxd_s[1] && r.rxd_s[2];

		// hidden receive timer, realigned on a start edge
		if (start_det)
		begin
			n.rx_cnt  = r.reload;
			n.rx_half = 1'b0;
		end
		else if (tick && run)
		begin
			if (r.rx_cnt == asp_pkg::ASP_LOW_TOP)
			begin
				n.rx_cnt = r.reload;
				rx_ovf   = 1'b1;
			end
			else
			begin
				n.rx_cnt = r.rx_cnt + 8'h01;
			end
		end

		// divide by two; receive samples on odd overflows, i.e. mid-bit
		n.tx_half = r.tx_half ^ tx_ovf;
		if (rx_ovf)
		begin
			n.rx_half = !r.rx_half;
		end
		tx_bit  = tx_ovf && r.tx_half;
		rx_samp = rx_ovf && !r.rx_half;

		// transmitter shifts the frame out on each bit tick
		if (tx_bit && r.tx_busy)
		begin
			if (r.tx_idx > last)
			begin
				n.tx_busy = 1'b0;
				n.txd     = 1'b1;
			end
			else
			begin
				n.txd      = r.tx_frame[0];
				n.tx_frame = {1'b1, r.tx_frame[10:1]};
				n.tx_idx   = r.tx_idx + 4'h1;
				ti_set     = r.tx_idx == last;
			end
		end

		// receiver
		unique case (r.rx_state)
			asp_pkg::ASP_RX_IDLE:
			begin
				if (start_det)
				begin
					n.rx_state = asp_pkg::ASP_RX_START;
				end
			end
			asp_pkg::ASP_RX_START:
			begin
				if (rx_samp)
				begin
					// a glitch that is high again mid-bit is no start
					n.rx_state = rxb ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_DATA;
					n.rx_idx   = 3'h0;
				end
			end
			asp_pkg::ASP_RX_DATA:
			begin
				if (rx_samp)
				begin
					n.rx_shift = {rxb, r.rx_shift[7:1]};
					n.rx_idx   = r.rx_idx + 3'h1;
					if (r.rx_idx == asp_pkg::ASP_DATA_LAST)
					begin
						n.rx_state = mode9 ? asp_pkg::ASP_RX_NINTH : asp_pkg::ASP_RX_STOP;
					end
				end
			end
			asp_pkg::ASP_RX_NINTH:
			begin
				if (rx_samp)
				begin
					n.rx_ninth = rxb;
					n.rx_state = asp_pkg::ASP_RX_STOP;
				end
			end
			asp_pkg::ASP_RX_STOP:
			begin
				if (rx_samp)
				begin
					rx_bit  = mode9 ? r.rx_ninth : rxb;
					rx_load = !r.ctrl[asp_pkg::ASP_CB_RI]
						&& (!r.ctrl[asp_pkg::ASP_CB_MCE] || rx_bit);
					n.rx_state = asp_pkg::ASP_RX_IDLE;
				end
			end
			default:
			begin
				n.rx_state = asp_pkg::ASP_RX_IDLE;
			end
		endcase
		if (rx_load)
		begin
			n.rx_buf = r.rx_shift;
		end

		// APB: answer registered in the setup cycle, write lands at access end
		n.rsp.pready  = setup;
		n.rsp.pslverr = setup && !asp_mapped(apb_req.paddr);
		if (setup && !apb_req.pwrite)
		begin
			n.rsp.prdata = 32'h0000_0000;
			unique case (apb_req.paddr)
				asp_pkg::ASP_OFF_CTRL:   n.rsp.prdata[7:0] = r.ctrl;
				asp_pkg::ASP_OFF_DATA:   n.rsp.prdata[7:0] = r.rx_buf;
				asp_pkg::ASP_OFF_RELOAD: n.rsp.prdata[7:0] = r.reload;
				asp_pkg::ASP_OFF_TCFG:   n.rsp.prdata[7:0] = r.tcfg;
				asp_pkg::ASP_OFF_LOW:    n.rsp.prdata[7:0] = r.low;
				default:                 n.rsp.prdata[7:0] = 8'h00;
			endcase
		end
		if (wr_ctrl)
		begin
			n.ctrl = apb_req.pwdata[7:0];
			n.ctrl[asp_pkg::ASP_CB_ONE] = 1'b1;
		end
		if (wr && asp_sel(apb_req.paddr, asp_pkg::ASP_OFF_DATA))
		begin
			// a write during a frame restarts with the new byte
			n.tx_frame = {1'b1, mode9 ? r.ctrl[asp_pkg::ASP_CB_TB8] : 1'b1,
				apb_req.pwdata[7:0], 1'b0};
			n.tx_busy  = 1'b1;
			n.tx_idx   = 4'h0;
		end
		if (wr && asp_sel(apb_req.paddr, asp_pkg::ASP_OFF_RELOAD))
		begin
			n.reload = apb_req.pwdata[7:0];
		end
		if (wr && asp_sel(apb_req.paddr, asp_pkg::ASP_OFF_TCFG))
		begin
			n.tcfg = apb_req.pwdata[7:0];
		end
		if (wr_low)
		begin
			n.low = apb_req.pwdata[7:0];
		end

		// hardware sets win over a clearing write in the same cycle
		if (ti_set)
		begin
			n.ctrl[asp_pkg::ASP_CB_TI] = 1'b1;
		end
		if (rx_load)
		begin
			n.ctrl[asp_pkg::ASP_CB_RI]  = 1'b1;
			n.ctrl[asp_pkg::ASP_CB_RB8] = rx_bit;
		end
		n.irq = n.tcfg[asp_pkg::ASP_TB_IEN]
			&& (n.ctrl[asp_pkg::ASP_CB_TI] || n.ctrl[asp_pkg::ASP_CB_RI]);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			r          <= '0;
			r.ctrl     <= asp_pkg::ASP_CTRL_RESET;
			r.tcfg     <= asp_pkg::ASP_TCFG_RESET;
			r.reload   <= asp_pkg::ASP_RELOAD_RESET;
			r.low      <= asp_pkg::ASP_LOW_RESET;
			r.rxd_s    <= 3'h7;
			r.txd      <= 1'b1;
			r.rx_state <= asp_pkg::ASP_RX_IDLE;
		end
		else
		begin
			r <= n;
		end
	end

	assign apb_rsp  = r.rsp;
	assign txd      = r.txd;
	assign port_irq = r.irq;

	property p_tx_start;
		@(posedge clk) disable iff (rst)
		wr && asp_sel(apb_req.paddr, asp_pkg::ASP_OFF_DATA) |=> r.tx_busy && r.tx_idx == 4'h0;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("data write did not start tx");
	property p_read_data;
		@(posedge clk) disable iff (rst)
		setup && !apb_req.pwrite && asp_sel(apb_req.paddr, asp_pkg::ASP_OFF_DATA)
			|=> r.rsp.prdata == {24'h00_0000, $past(r.rx_buf)} && r.rsp.pready;
	endproperty
	a_read_data: assert property (p_read_data) else $error("data read not rx buffer");
	property p_irq;
		@(posedge clk) disable iff (rst)
		r.tcfg[asp_pkg::ASP_TB_IEN] && $rose(r.ctrl[asp_pkg::ASP_CB_RI]) |-> port_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("no interrupt on rx done");
	property p_flag_hold;
		@(posedge clk) disable iff (rst)
		r.ctrl[asp_pkg::ASP_CB_TI] && !wr_ctrl |=> r.ctrl[asp_pkg::ASP_CB_TI];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("tx done dropped by hw");
	property p_reload;
		@(posedge clk) disable iff (rst)
		tick && run && r.low == asp_pkg::ASP_LOW_TOP && !wr_low |=> r.low == $past(r.reload);
	endproperty
	a_reload: assert property (p_reload) else $error("low count missed reload");
	property p_rx_force;
		@(posedge clk) disable iff (rst)
		start_det |=> r.rx_cnt == $past(r.reload) && !r.rx_half
			&& r.rx_state == asp_pkg::ASP_RX_START;
	endproperty
	a_rx_force: assert property (p_rx_force) else $error("rx timer not realigned");
	property p_ti_stop;
		@(posedge clk) disable iff (rst)
		ti_set |=> r.txd && r.ctrl[asp_pkg::ASP_CB_TI] && r.tx_busy;
	endproperty
	a_ti_stop: assert property (p_ti_stop) else $error("tx done not at stop bit");
	property p_rx_load;
		@(posedge clk) disable iff (rst)
		$changed(r.rx_buf) |-> $past(r.rx_state) == asp_pkg::ASP_RX_STOP
			&& !$past(r.ctrl[asp_pkg::ASP_CB_RI]) && r.ctrl[asp_pkg::ASP_CB_RI];
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("rx buffer loaded wrongly");
	property p_start_bit;
		@(posedge clk) disable iff (rst)
		tx_bit && r.tx_busy && r.tx_idx == 4'h0 && !wr |=> !r.txd;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit not low");
	c_tx_done: cover property (@(posedge clk) disable iff (rst) ti_set);
	c_rx_load: cover property (@(posedge clk) disable iff (rst) rx_load);
	c_rx_reject: cover property (@(posedge clk) disable iff (rst)
		r.rx_state == asp_pkg::ASP_RX_STOP && rx_samp && !rx_load);
	c_false_start: cover property (@(posedge clk) disable iff (rst)
		r.rx_state == asp_pkg::ASP_RX_START && rx_samp && rxb);

endmodule

// ---- bench/asp_remote_uart.sv ----
// Purpose: far-end serial transceiver facing the port
// Assumes: bit period in clk cycles, line idle high
// Notes:   receiver times bits from the rise that ends the start bit, so data lsb must be 1
`timescale 1ns/10ps
module asp_remote_uart
(
	input  wire logic       clk,
	input  wire logic       line_in,
	output      logic       line_out,
	input  wire logic [31:0] bit_clks,
	input  wire logic       nine,
	output      logic [7:0] got_data,
	output      logic       got_ninth,
	output      logic       got_stop,
	output      int         got_cnt,
	output      int         start_len
);
	int         len;
	logic [7:0] sh;

	initial
	begin
		line_out = 1'b1;
	end

	// short low pulse, gone again before mid-bit
	task automatic glitch(input int w);
		@(posedge clk);
		line_out <= 1'b0;
		repeat (w) @(posedge clk);
		line_out <= 1'b1;
	endtask

	// start low, data lsb first, ninth only in 9-bit frames, stop high
	task automatic send(input logic [7:0] d, input logic b9);
		logic [10:0] f;
		f = {1'b1, nine ? b9 : 1'b1, d, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++)
		begin
			@(posedge clk);
			line_out <= f[i];
			repeat (bit_clks - 1) @(posedge clk);
		end
	endtask

	always
	begin
		@(posedge clk);
		if (line_in === 1'b0)
		begin
			len = 0;
			while (line_in === 1'b0 && len < 4096)
			begin
				len++;
				@(posedge clk);
			end
			start_len = len;
			for (int i = 0; i < 8; i++)
			begin
				repeat (i == 0 ? bit_clks / 2 : bit_clks) @(posedge clk);
				sh[i] = line_in;
			end
			if (nine)
			begin
				repeat (bit_clks) @(posedge clk);
				got_ninth = line_in;
			end
			repeat (bit_clks) @(posedge clk);
			got_stop = line_in;
			got_data = sh;
			got_cnt++;
		end
	end
endmodule

// ---- bench/async_serial_port_baud_gen_bench.sv ----
// Purpose: self-checking bench for the serial port
// Assumes: reload 8'hFC, so eight clk per bit from the system clock
// Notes:   oscillator and timer pin toggle free, well under clk/4
`timescale 1ns/10ps
module async_serial_port_baud_gen_bench;
	logic                  clk;
	logic                  rst;
	asp_pkg::asp_apb_req_t req;
	asp_pkg::asp_apb_rsp_t rsp;
	logic                  rxd;
	logic                  txd;
	logic                  ext_osc;
	logic                  tin;
	logic                  irq;
	logic                  nine;
	int                    far_bits;
	logic [7:0]            far_data;
	logic                  far_ninth;
	logic                  far_stop;
	int                    far_cnt;
	int                    far_start;
	int                    err_count;
	int                    checks_done;
	logic [1:0]            osc_cnt;
	logic [2:0]            tin_cnt;

	asp_serial_port uut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .rxd(rxd),
		.txd(txd), .ext_osc(ext_osc), .timer_ext_input(tin), .port_irq(irq));
	asp_remote_uart far (.clk(clk), .line_in(txd), .line_out(rxd), .bit_clks(far_bits),
		.nine(nine), .got_data(far_data), .got_ninth(far_ninth), .got_stop(far_stop),
		.got_cnt(far_cnt), .start_len(far_start));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// oscillator rising edge every 8 clk, pin rising edge every 6 clk
	always @(posedge clk)
	begin
		osc_cnt <= osc_cnt + 2'h1;
		if (osc_cnt == 2'h3)
			ext_osc <= ~ext_osc;
		tin_cnt <= (tin_cnt == 3'h2) ? 3'h0 : tin_cnt + 3'h1;
		if (tin_cnt == 3'h2)
			tin <= ~tin;
	end

	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 50);
		chk("pready", 32'h1, {31'h0, rsp.pready});
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, {24'h0, d}, q, e);
		chk("write err", 32'h0, {31'h0, e});
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] q;
		logic        e;
		xfer(1'b0, a, 32'h0, q, e);
		chk(nm, {24'h0, exp}, q);
	endtask

	task automatic wait_far(input int c0, input int lim);
		int n;
		n = 0;
		while (far_cnt == c0 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		chk("far frame", c0 + 1, far_cnt);
	endtask

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk("port_irq", 32'h1, {31'h0, irq});
	endtask

	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		chk("txd idle", 32'h1, {31'h0, txd});
		chk("irq idle", 32'h0, {31'h0, irq});
		rd("ctrl", asp_pkg::ASP_OFF_CTRL, asp_pkg::ASP_CTRL_RESET);
		rd("tcfg", asp_pkg::ASP_OFF_TCFG, asp_pkg::ASP_TCFG_RESET);
		rd("reload", asp_pkg::ASP_OFF_RELOAD, asp_pkg::ASP_RELOAD_RESET);
		rd("low", asp_pkg::ASP_OFF_LOW, asp_pkg::ASP_LOW_RESET);
		xfer(1'b0, 8'h14, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
	endtask

	task automatic t_rx;
		wr(asp_pkg::ASP_OFF_CTRL, 8'h10);
		wr(asp_pkg::ASP_OFF_RELOAD, 8'hFC);
		wr(asp_pkg::ASP_OFF_TCFG, 8'h11);
		repeat (3) @(posedge clk);
		far.glitch(2);
		repeat (20) @(posedge clk);
		rd("glitch", asp_pkg::ASP_OFF_CTRL, 8'h50);
		far.send(8'h5A, 1'b0);
		wait_irq();
		rd("ctrl rx", asp_pkg::ASP_OFF_CTRL, 8'h55);
		rd("rx data", asp_pkg::ASP_OFF_DATA, 8'h5A);
		fork
			far.send(8'h96, 1'b0);
			begin
				repeat (30) @(posedge clk);
				wr(asp_pkg::ASP_OFF_CTRL, 8'h10);
			end
		join
		wait_irq();
		rd("second byte", asp_pkg::ASP_OFF_DATA, 8'h96);
		far.send(8'h11, 1'b0);
		repeat (20) @(posedge clk);
		rd("overrun data", asp_pkg::ASP_OFF_DATA, 8'h96);
		rd("flag held", asp_pkg::ASP_OFF_CTRL, 8'h55);
		wr(asp_pkg::ASP_OFF_CTRL, 8'hB0);
		nine = 1'b1;
		far.send(8'h77, 1'b0);
		repeat (20) @(posedge clk);
		rd("filtered", asp_pkg::ASP_OFF_CTRL, 8'hF0);
		far.send(8'h78, 1'b1);
		wait_irq();
		rd("ninth rx", asp_pkg::ASP_OFF_CTRL, 8'hF5);
		rd("addr byte", asp_pkg::ASP_OFF_DATA, 8'h78);
	endtask

	task automatic t_tx;
		int c;
		int n;
		wr(asp_pkg::ASP_OFF_CTRL, 8'h00);
		nine = 1'b0;
		c = far_cnt;
		wr(asp_pkg::ASP_OFF_DATA, 8'hA5);
		n = 0;
		while (txd !== 1'b0 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (irq !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		// stop drives after nine bits of 8 clk, irq in the same cycle as the flag
		chk("done at stop", 32'h1, {31'h0, n >= 72 && n <= 74});
		chk("stop level", 32'h1, {31'h0, txd});
		wait_far(c, 200);
		chk("tx data", 32'hA5, {24'h0, far_data});
		chk("tx stop", 32'h1, {31'h0, far_stop});
		rd("tx flag", asp_pkg::ASP_OFF_CTRL, 8'h42);
		rd("no readback", asp_pkg::ASP_OFF_DATA, 8'h78);
		wr(asp_pkg::ASP_OFF_CTRL, 8'h88);
		nine = 1'b1;
		c = far_cnt;
		wr(asp_pkg::ASP_OFF_DATA, 8'h3D);
		wait_far(c, 300);
		chk("tx9 data", 32'h3D, {24'h0, far_data});
		chk("tx9 ninth", 32'h1, {31'h0, far_ninth});
		rd("ctrl tx9", asp_pkg::ASP_OFF_CTRL, 8'hCA);
		repeat (8) @(posedge clk);
		nine = 1'b0;
	endtask

	task automatic t_src;
		int         c;
		int         b[6] = '{8, 32, 96, 384, 512, 48};
		logic [2:0] s[6] = '{asp_pkg::ASP_SRC_SYS, asp_pkg::ASP_SRC_DIV4,
			asp_pkg::ASP_SRC_DIV12, asp_pkg::ASP_SRC_DIV48, asp_pkg::ASP_SRC_OSC8,
			asp_pkg::ASP_SRC_PIN};
		for (int i = 0; i < 6; i++)
		begin
			wr(asp_pkg::ASP_OFF_TCFG, {4'h0, s[i], 1'b1});
			wr(asp_pkg::ASP_OFF_CTRL, 8'h00);
			far_bits = b[i];
			c = far_cnt;
			wr(asp_pkg::ASP_OFF_DATA, 8'hC3);
			wait_far(c, 12 * b[i] + 100);
			chk("bit period", b[i], far_start);
			chk("src data", 32'hC3, {24'h0, far_data});
			chk("irq masked", 32'h0, {31'h0, irq});
			rd("tx done", asp_pkg::ASP_OFF_CTRL, 8'h42);
			repeat (b[i]) @(posedge clk);
		end
		// source code 6 gives no ticks: low count holds, no frame leaves
		wr(asp_pkg::ASP_OFF_TCFG, {4'h0, 3'h6, 1'b1});
		wr(asp_pkg::ASP_OFF_LOW, 8'hFE);
		wr(asp_pkg::ASP_OFF_CTRL, 8'h00);
		wr(asp_pkg::ASP_OFF_DATA, 8'h5A);
		repeat (100) @(posedge clk);
		chk("no tick txd", 32'h1, {31'h0, txd});
		rd("no tick low", asp_pkg::ASP_OFF_LOW, 8'hFE);
		rd("no tick done", asp_pkg::ASP_OFF_CTRL, 8'h40);
	endtask

	initial
	begin
		rst = 1'b1;
		req = '0;
		ext_osc = 1'b0;
		tin = 1'b0;
		osc_cnt = 2'h0;
		tin_cnt = 3'h0;
		nine = 1'b0;
		far_bits = 8;
		err_count = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rx();
		t_tx();
		t_src();
		summarize();
	end

	// whole run is near 13k cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		err_count++;
		summarize();
	end
endmodule
